// >>> lviw_defs.vh
// Purpose: constants for the low-voltage interrupt and wake-up block
// Assumes: 8-bit register port, byte-wide registers
// Notes:   offsets are byte addresses on the register port
`ifndef LVIW_DEFS_VH
`define LVIW_DEFS_VH

// register offsets
`define LVIW_ADDR_OPT        8'h0f
`define LVIW_ADDR_TCTL       8'h12
`define LVIW_ADDR_TSTAT      8'h13
`define LVIW_ADDR_KEYCTL     8'h14
`define LVIW_ADDR_PWRCTL     8'h15
`define LVIW_ADDR_COND       8'h16
`define LVIW_ADDR_VECTOR     8'h17
`define LVIW_ADDR_TEVENT     8'h18

// low_voltage_and_options fields
`define LVIW_OPT_FLAG        7
`define LVIW_OPT_VALID       6
`define LVIW_OPT_CLEAR       5
`define LVIW_OPT_ENABLE      4
`define LVIW_OPT_COP         1
`define LVIW_OPT_IRQMODE     0

// timer fields (status and control share positions)
`define LVIW_TIM_CAPTURE     7
`define LVIW_TIM_COMPARE     6
`define LVIW_TIM_OVERFLOW    5

// keypad control fields
`define LVIW_KEY_ENABLE      1
`define LVIW_KEY_FLAG        0

// power control fields (write 1 to enter)
`define LVIW_PWR_STOP        0
`define LVIW_PWR_WAIT        1

// condition code register: interrupt mask bit, fixed top bits
`define LVIW_COND_MASK       3
`define LVIW_COND_RESET      8'hf8

// vector addresses (high byte location)
`define LVIW_VEC_RESET       16'h1ffe
`define LVIW_VEC_SWI         16'h1ffc
`define LVIW_VEC_EXT         16'h1ffa
`define LVIW_VEC_CORE        16'h1ff8
`define LVIW_VEC_LOWV        16'h1ff6
`define LVIW_VEC_TIMER       16'h1ff4
`define LVIW_VEC_KEY         16'h1ff2

`define LVIW_ZERO8           8'h00
`define LVIW_SYNC_STAGES     2

`endif

// >>> lviw_sync.v
// Purpose: two-flop synchroniser for a level input
// Assumes: single clock, asynchronous active-high reset
// Notes:   first stage is read only by the second stage
`timescale 1ns/10ps
module lviw_sync #(
   parameter RESET_LEVEL = 1'b1
) (
   input  wire clk,
   input  wire reset,
   input  wire din,
   output reg  dout
);
   reg stage1;

   // two flip-flops in series
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         stage1 <= RESET_LEVEL;
         dout   <= RESET_LEVEL;
      end else begin
         stage1 <= din;
         dout   <= stage1;
      end
   end
endmodule

// >>> lviw_interrupt_wakeup.v
// Purpose: low-voltage indicator interrupt, timer/keypad routing, vectoring, wake-up
// Assumes: register port with one-cycle read latency; inputs synchronous except the pin
// Notes:   vector output is the high-byte location of the winning source
`timescale 1ns/10ps
`include "lviw_defs.vh"

// Contract
// - low indicator pin clears the voltage-valid status bit
// - valid bit zero requests an interrupt only while enable bit set
// - top bit of options register shows a valid low-voltage interrupt occurred
// - low-voltage interrupt uses its own dedicated vector pair
// - clear bit is write-only, reads zero; writing one clears pending request
// - enabled: interrupt on both pin edges, except first rise after power-on
// - disabled: pin edges raise no interrupt; software polls falling edge
// - power-on with low supply: no interrupt, start-up held until pin high
// - pin returning high wakes CPU and restarts clock halted by STOP; code wakes from STOP on a pin edge only while enable bit set
// - timer requests one shared interrupt when any enabled flag set
// - three timer enables in control register gate their flags
// - port C inputs form wired-OR keypad interrupt gated by enable, own vector
// - reset loads start address from reset vector and sets interrupt mask
// - STOP turns oscillator off and halts all processing incl. timers, watchdog
// - WAIT suspends CPU while core timer, 16-bit timer, converter run
// - WAIT ends on enabled external, keypad, low-voltage, core or 16-bit timer
// - mask bit set holds off all maskable requests until cleared
module lviw_interrupt_wakeup #(
   parameter DATA_W = 8,
   parameter ADDR_W = 8,
   parameter KEY_W  = 8
) (
   input  wire              clk,
   input  wire              reset,
   input  wire              powerOnReset,
   input  wire              lowVoltageIndicatorPin_n,
   input  wire [ADDR_W-1:0] regAddr,
   input  wire [DATA_W-1:0] regWriteData,
   input  wire              regWrite,
   input  wire              regRead,
   output reg  [DATA_W-1:0] regReadData,
   input  wire [KEY_W-1:0]  keypadPins_n,
   input  wire [KEY_W-1:0]  keypadInputMask,
   input  wire              externalIrqRequest,
   input  wire              coreTimerRequest,
   input  wire              captureEvent,
   input  wire              compareEvent,
   input  wire              overflowEvent,
   input  wire              vectorTaken,
   input  wire              swiTaken,
   output wire              irqRequest,
   output reg  [15:0]       vectorAddress,
   output reg               cpuRun,
   output reg               oscillatorEnable,
   output reg               timersRun,
   output reg               startupHold
);
   // one-hot power states
   localparam [2:0] ST_RUN  = 3'b001;
   localparam [2:0] ST_WAIT = 3'b010;
   localparam [2:0] ST_STOP = 3'b100;

   reg [2:0]  state;
   reg [2:0]  next_state;
   wire       pinLevel;
   reg        pinLast;
   reg        firstRiseArmed;
   reg        lowVoltageIrqFlag;
   reg        lowVoltageIrqEnable;
   reg        copOption;
   reg        irqModeOption;
   reg [2:0]  timerEnables;
   reg [2:0]  timerFlags;
   reg        keypadIrqEnable;
   reg        keypadFlag;
   reg        interruptMask;
   reg        pinSeen;
   wire       pinRise;
   wire       pinFall;
   wire       pinEdge;
   wire       timerRequest;
   wire       keypadActive;
   wire       keypadRequest;
   wire       lowVoltageRequest;
   wire       anyEnabled;
   wire       clearLowVoltage;
   wire       wrOpt;
   wire       wrTctl;
   wire       wrTstat;
   wire       wrKey;
   wire       wrPwr;
   wire       wrCond;

   // pin synchroniser; reset level high as the pin idles high
   // the pin comes from an analogue detector with no clock relation,
   // so nothing but the synchroniser output may feed the edge logic
   lviw_sync #(
      .RESET_LEVEL (1'b1)
   ) u_pinSync (
      .clk   (clk),
      .reset (reset),
      .din   (lowVoltageIndicatorPin_n),
      .dout  (pinLevel)
   );

   // write decode helper
   function hit;
      input [ADDR_W-1:0] addr;
      input [ADDR_W-1:0] target;
      begin
         hit = (addr == target);
      end
   endfunction

   assign wrOpt   = regWrite && hit(regAddr, `LVIW_ADDR_OPT);
   assign wrTctl  = regWrite && hit(regAddr, `LVIW_ADDR_TCTL);
   assign wrTstat = regWrite && hit(regAddr, `LVIW_ADDR_TSTAT);
   assign wrKey   = regWrite && hit(regAddr, `LVIW_ADDR_KEYCTL);
   assign wrPwr   = regWrite && hit(regAddr, `LVIW_ADDR_PWRCTL);
   assign wrCond  = regWrite && hit(regAddr, `LVIW_ADDR_COND);

   // edges seen only after synchronising
   assign pinRise  = pinLevel && !pinLast;
   assign pinFall  = !pinLevel && pinLast;
   // first rise after power-on is swallowed
   assign pinEdge  = pinFall || (pinRise && !firstRiseArmed);
   assign clearLowVoltage = wrOpt && regWriteData[`LVIW_OPT_CLEAR];

   // pin history and power-on first-rise tracking
   // history resets high like the idle pin, so reset alone makes no edge;
   // a pin already high when power-on ends counts as the swallowed rise
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         pinLast        <= 1'b1;
         firstRiseArmed <= 1'b1;
         pinSeen        <= 1'b0;
      end else begin
         pinLast <= pinLevel;
         if (powerOnReset) begin
            firstRiseArmed <= 1'b1;
            pinSeen        <= 1'b0;
         end else if (pinRise) begin
            firstRiseArmed <= 1'b0;
            pinSeen        <= 1'b1;
         end else if (pinLevel && !pinSeen) begin
            firstRiseArmed <= 1'b0;                   // pin already high at power-on
            pinSeen        <= 1'b1;
         end
      end
   end

   // start-up held while pin low after power-on
   // the hold also blocks the request and pins the reset vector
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         startupHold <= 1'b1;
      end else if (powerOnReset) begin
         startupHold <= 1'b1;
      end else if (pinLevel) begin
         startupHold <= 1'b0;
      end
   end

   // low-voltage pending flag: set wins over clear, no set while held at start-up
   // the service routine must write the clear bit; an edge landing on that
   // same cycle keeps the flag so the second event is not lost
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         lowVoltageIrqFlag <= 1'b0;
      end else if (pinEdge && lowVoltageIrqEnable && !startupHold) begin
         lowVoltageIrqFlag <= 1'b1;
      end else if (clearLowVoltage) begin
         lowVoltageIrqFlag <= 1'b0;
      end
   end

   // option, control and mask registers
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         lowVoltageIrqEnable <= 1'b0;
         copOption           <= 1'b0;
         irqModeOption       <= 1'b0;
         timerEnables        <= 3'h0;
         keypadIrqEnable     <= 1'b0;
         interruptMask       <= 1'b1;
      end else begin
         if (wrOpt) begin
            lowVoltageIrqEnable <= regWriteData[`LVIW_OPT_ENABLE];
            copOption           <= regWriteData[`LVIW_OPT_COP];
            irqModeOption       <= regWriteData[`LVIW_OPT_IRQMODE];
         end
         if (wrTctl) begin
            timerEnables <= regWriteData[`LVIW_TIM_CAPTURE:`LVIW_TIM_OVERFLOW];
         end
         if (wrKey) begin
            keypadIrqEnable <= regWriteData[`LVIW_KEY_ENABLE];
         end
         if (vectorTaken || swiTaken) begin
            interruptMask <= 1'b1;
         end else if (wrCond) begin
            interruptMask <= regWriteData[`LVIW_COND_MASK];
         end
      end
   end

   // timer flags: event sets, writing one clears, set wins
   // events are ignored while the timers are halted in stop
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         timerFlags <= 3'h0;
      end else if (timersRun) begin
         timerFlags <= {captureEvent, compareEvent, overflowEvent}
                       | (timerFlags
                          & ~(wrTstat ? regWriteData[`LVIW_TIM_CAPTURE:`LVIW_TIM_OVERFLOW]
                                      : 3'h0));
      end else if (wrTstat) begin
         timerFlags <= timerFlags & ~regWriteData[`LVIW_TIM_CAPTURE:`LVIW_TIM_OVERFLOW];
      end
   end

   // keypad: wired-OR of low input pins selected by keypadInputMask
   assign keypadActive = |(~keypadPins_n & keypadInputMask);
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         keypadFlag <= 1'b0;
      end else if (keypadActive) begin
         keypadFlag <= 1'b1;
      end else if (wrKey && regWriteData[`LVIW_KEY_FLAG]) begin
         keypadFlag <= 1'b0;
      end
   end

   // per-source requests
   assign lowVoltageRequest = lowVoltageIrqFlag && lowVoltageIrqEnable;
   assign timerRequest  = |(timerFlags & timerEnables);
   assign keypadRequest = keypadFlag && keypadIrqEnable;
   assign anyEnabled    = externalIrqRequest || coreTimerRequest || lowVoltageRequest
                          || timerRequest || keypadRequest;

   // CPU request gated by the mask and start-up hold
   assign irqRequest = anyEnabled && !interruptMask && !startupHold;

   // vector selection by priority
   // the register keeps the last winner, so the fetch still sees it
   // when the request has already been cleared
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         vectorAddress <= `LVIW_VEC_RESET;
      end else if (startupHold) begin
         vectorAddress <= `LVIW_VEC_RESET;
      end else if (swiTaken) begin
         vectorAddress <= `LVIW_VEC_SWI;
      end else if (externalIrqRequest) begin
         vectorAddress <= `LVIW_VEC_EXT;
      end else if (coreTimerRequest) begin
         vectorAddress <= `LVIW_VEC_CORE;
      end else if (lowVoltageRequest) begin
         vectorAddress <= `LVIW_VEC_LOWV;
      end else if (timerRequest) begin
         vectorAddress <= `LVIW_VEC_TIMER;
      end else if (keypadRequest) begin
         vectorAddress <= `LVIW_VEC_KEY;
      end
   end

   // power state: wake on any enabled source
   // stop only wakes on sources that need no running timer, since the
   // timers are frozen there and could never raise their flags
   always @* begin
      next_state = state;
      case (state)
         ST_RUN: begin
            if (wrPwr && regWriteData[`LVIW_PWR_STOP]) begin
               next_state = ST_STOP;
            end else if (wrPwr && regWriteData[`LVIW_PWR_WAIT]) begin
               next_state = ST_WAIT;
            end
         end
         ST_WAIT: begin
            if (anyEnabled) begin
               next_state = ST_RUN;
            end
         end
         ST_STOP: begin
            if (pinEdge && lowVoltageIrqEnable) begin
               next_state = ST_RUN;
            end else if (externalIrqRequest || keypadRequest) begin
               next_state = ST_RUN;
            end
         end
         default: begin
            next_state = ST_RUN;
         end
      endcase
   end

   always @(posedge clk or posedge reset) begin
      if (reset) begin
         state <= ST_RUN;
      end else begin
         state <= next_state;
      end
   end

   // run controls derived from the next state
   // so they change on the same edge as the state itself
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         cpuRun           <= 1'b1;
         oscillatorEnable <= 1'b1;
         timersRun        <= 1'b1;
      end else begin
         cpuRun           <= (next_state == ST_RUN);
         oscillatorEnable <= (next_state != ST_STOP);
         timersRun        <= (next_state != ST_STOP);
      end
   end

   // register read port, data one cycle after strobe
   // data stands one cycle only and is zero otherwise
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         regReadData <= `LVIW_ZERO8;
      end else if (regRead) begin
         if (hit(regAddr, `LVIW_ADDR_OPT)) begin
            regReadData <= {lowVoltageIrqFlag,
                            pinLevel,
                            1'b0,
                            lowVoltageIrqEnable, 2'b00, copOption, irqModeOption};
         end else if (hit(regAddr, `LVIW_ADDR_TCTL)) begin
            regReadData <= {timerEnables, 5'h00};
         end else if (hit(regAddr, `LVIW_ADDR_TSTAT)) begin
            regReadData <= {timerFlags, 5'h00};
         end else if (hit(regAddr, `LVIW_ADDR_KEYCTL)) begin
            regReadData <= {6'h00, keypadIrqEnable, keypadFlag};
         end else if (hit(regAddr, `LVIW_ADDR_COND)) begin
            regReadData <= `LVIW_COND_RESET & ~({4'h0, ~interruptMask, 3'h0});
         end else if (hit(regAddr, `LVIW_ADDR_VECTOR)) begin
            regReadData <= vectorAddress[7:0];
         end else begin
            regReadData <= `LVIW_ZERO8;
         end
      end else begin
         regReadData <= `LVIW_ZERO8;
      end
   end
endmodule

// >>> lviw_supply_monitor.sv
// Purpose: external supply detector that drives the active-low indicator pin
// Assumes: supply state is commanded by the bench
// Notes:   pin follows the supply after a short detector delay
`timescale 1ns/10ps
module lviw_supply_monitor #(
   parameter DELAY_NS = 7
) (
   input  wire supplyOk,
   output wire lowVoltageIndicatorPin_n
);
   // detector keeps the pin high while the supply is good, power-on included
   assign #(DELAY_NS) lowVoltageIndicatorPin_n = supplyOk;
endmodule

// >>> lviw_interrupt_wakeup_assertions.sv
// Purpose: port-level checks of the indicator interrupt and power control
// Assumes: one clock, asynchronous active-high reset
// Notes:   enable shadow follows register writes only; mask shadow also sets on vector fetch
`timescale 1ns/10ps
`include "lviw_defs.vh"
module lviw_checker #(
   parameter DATA_W = 8,
   parameter ADDR_W = 8
) (
   input wire              clk,
   input wire              reset,
   input wire              lowVoltageIndicatorPin_n,
   input wire [ADDR_W-1:0] regAddr,
   input wire [DATA_W-1:0] regWriteData,
   input wire              regWrite,
   input wire              regRead,
   input wire [DATA_W-1:0] regReadData,
   input wire              vectorTaken,
   input wire              irqRequest,
   input wire [15:0]       vectorAddress,
   input wire              cpuRun,
   input wire              oscillatorEnable,
   input wire              timersRun,
   input wire              startupHold
);
   reg pinIrqEnable;
   reg maskSet;
   // shadows of the indicator enable bit and the interrupt mask
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         pinIrqEnable <= 1'b0;
         maskSet      <= 1'b1;
      end else begin
         if (regWrite && regAddr == `LVIW_ADDR_OPT)
            pinIrqEnable <= regWriteData[4];
         if (vectorTaken)
            maskSet <= 1'b1;
         else if (regWrite && regAddr == `LVIW_ADDR_COND)
            maskSet <= regWriteData[3];
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   a_clear_reads_zero: assert property (regRead && regAddr == `LVIW_ADDR_OPT
      |=> !regReadData[5]) else $error("clear bit read back as one");
   a_valid_tracks_pin: assert property ($stable(lowVoltageIndicatorPin_n) [*4]
      ##0 (regRead && regAddr == `LVIW_ADDR_OPT)
      |=> regReadData[6] == $past(lowVoltageIndicatorPin_n)) else $error("valid bit wrong");
   a_stop_halts_all: assert property (regWrite && regAddr == `LVIW_ADDR_PWRCTL
      && regWriteData[0] |=> !oscillatorEnable && !timersRun && !cpuRun)
      else $error("stop did not halt");
   a_wait_keeps_timers: assert property (regWrite && regAddr == `LVIW_ADDR_PWRCTL
      && regWriteData == 8'h02 |=> (timersRun && oscillatorEnable) [*3])
      else $error("wait stopped timers");
   a_mask_holds_off: assert property (vectorTaken || (regWrite
      && regAddr == `LVIW_ADDR_COND && regWriteData[3]) |=> !irqRequest)
      else $error("request while masked");
   a_hold_blocks_irq: assert property (startupHold |-> !irqRequest)
      else $error("request during start-up hold");
   a_reset_vector: assert property ($past(reset)
      |-> vectorAddress == `LVIW_VEC_RESET && !irqRequest) else $error("bad reset vector");
   a_edge_raises_irq: assert property (pinIrqEnable && !maskSet && !startupHold
      && $changed(lowVoltageIndicatorPin_n) |-> ##[1:3] irqRequest)
      else $error("pin edge raised no request");
endmodule
bind lviw_interrupt_wakeup lviw_checker #(.DATA_W(DATA_W), .ADDR_W(ADDR_W)) i_checker (
   .clk(clk), .reset(reset), .lowVoltageIndicatorPin_n(lowVoltageIndicatorPin_n),
   .regAddr(regAddr), .regWriteData(regWriteData), .regWrite(regWrite), .regRead(regRead),
   .regReadData(regReadData), .vectorTaken(vectorTaken), .irqRequest(irqRequest),
   .vectorAddress(vectorAddress), .cpuRun(cpuRun), .oscillatorEnable(oscillatorEnable),
   .timersRun(timersRun), .startupHold(startupHold));

// >>> lviw_tb.sv
// Purpose: self-checking bench for the indicator interrupt and wake-up block
// Assumes: 10 MHz clock, supply monitor model on the indicator pin
// Notes:   pin edges need three clock edges to reach the flag and four to reach the vector
`timescale 1ns/10ps
`include "lviw_defs.vh"
module testbench;
   reg         clk, reset, powerOnReset, supplyOk, regWrite, regRead, vectorTaken;
   reg  [7:0]  regAddr, regWriteData, keypadPins_n, keypadInputMask;
   reg         externalIrqRequest, coreTimerRequest;
   reg  [2:0]  timerEvent;
   wire        indicatorPin_n, irqRequest, cpuRun, oscillatorEnable, timersRun, startupHold;
   wire [7:0]  regReadData;
   wire [15:0] vectorAddress;
   integer     nErrors, testsRun;
   lviw_supply_monitor i_monitor (.supplyOk(supplyOk), .lowVoltageIndicatorPin_n(indicatorPin_n));
   lviw_interrupt_wakeup i_dut (
      .clk(clk), .reset(reset), .powerOnReset(powerOnReset),
      .lowVoltageIndicatorPin_n(indicatorPin_n), .regAddr(regAddr),
      .regWriteData(regWriteData), .regWrite(regWrite), .regRead(regRead),
      .regReadData(regReadData), .keypadPins_n(keypadPins_n),
      .keypadInputMask(keypadInputMask), .externalIrqRequest(externalIrqRequest),
      .coreTimerRequest(coreTimerRequest), .captureEvent(timerEvent[2]),
      .compareEvent(timerEvent[1]), .overflowEvent(timerEvent[0]),
      .vectorTaken(vectorTaken), .swiTaken(1'b0), .irqRequest(irqRequest),
      .vectorAddress(vectorAddress), .cpuRun(cpuRun), .oscillatorEnable(oscillatorEnable),
      .timersRun(timersRun), .startupHold(startupHold));
   // compare and count
   task chk(input [15:0] seen, input [15:0] exp);
      begin
         testsRun = testsRun + 1;
         if (seen !== exp) begin
            nErrors = nErrors + 1;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
         end
      end
   endtask
   task endOfTest;
      begin
         if (nErrors == 0 && testsRun > 0)
            $display("RESULT: PASS");
         else
            $display("RESULT: FAIL");
         $finish;
      end
   endtask
   // one-cycle register write, ends at the negedge after it is taken
   task wr(input [7:0] a, input [7:0] d);
      begin
         @(posedge clk);
         regWrite <= 1'b1;
         regAddr <= a;
         regWriteData <= d;
         @(posedge clk);
         regWrite <= 1'b0;
         @(negedge clk);
      end
   endtask
   task rd(input [7:0] a, input [7:0] e);
      begin
         @(posedge clk);
         regRead <= 1'b1;
         regAddr <= a;
         @(posedge clk);
         regRead <= 1'b0;
         @(negedge clk);
         chk(regReadData, e);
      end
   endtask
   task setSupply(input v);
      begin
         @(posedge clk);
         supplyOk <= v;
         repeat (5) @(posedge clk);
      end
   endtask
   task seeIrq(input e);
      begin
         @(negedge clk);
         chk(irqRequest, e);
      end
   endtask
   // power-on with low supply, then first rise
   task tPowerOn;
      begin
         @(negedge clk);
         chk(vectorAddress, `LVIW_VEC_RESET);
         wr(`LVIW_ADDR_OPT, 8'h10);
         wr(`LVIW_ADDR_COND, 8'h00);
         @(posedge clk);
         powerOnReset <= 1'b0;
         repeat (8) @(posedge clk);
         seeIrq(1'b0);
         chk(startupHold, 1'b1);
         setSupply(1'b1);
         @(negedge clk);
         chk(startupHold, 1'b0);
         if (startupHold !== 1'b0)
            endOfTest;
         seeIrq(1'b0);
         rd(`LVIW_ADDR_OPT, 8'h50);
      end
   endtask
   // both edges with the enable set, clear by write
   task tEdges;
      begin
         setSupply(1'b0);
         seeIrq(1'b1);
         chk(vectorAddress, `LVIW_VEC_LOWV);
         rd(`LVIW_ADDR_OPT, 8'h90);
         rd(`LVIW_ADDR_OPT, 8'h90);
         wr(`LVIW_ADDR_OPT, 8'h30);
         seeIrq(1'b0);
         rd(`LVIW_ADDR_OPT, 8'h10);
         setSupply(1'b1);
         seeIrq(1'b1);
         rd(`LVIW_ADDR_OPT, 8'hd0);
         wr(`LVIW_ADDR_OPT, 8'h30);
      end
   endtask
   task tDisabled;
      begin
         wr(`LVIW_ADDR_OPT, 8'h00);
         setSupply(1'b0);
         seeIrq(1'b0);
         rd(`LVIW_ADDR_OPT, 8'h00);
         setSupply(1'b1);
         seeIrq(1'b0);
         rd(`LVIW_ADDR_OPT, 8'h40);
         wr(`LVIW_ADDR_OPT, 8'h10);
      end
   endtask
   // mask held off, then taken and set again by the vector fetch
   task tMask;
      begin
         wr(`LVIW_ADDR_COND, 8'h08);
         rd(`LVIW_ADDR_COND, 8'hf8);
         setSupply(1'b0);
         seeIrq(1'b0);
         wr(`LVIW_ADDR_COND, 8'h00);
         seeIrq(1'b1);
         @(posedge clk);
         vectorTaken <= 1'b1;
         @(posedge clk);
         vectorTaken <= 1'b0;
         seeIrq(1'b0);
         wr(`LVIW_ADDR_OPT, 8'h30);
         wr(`LVIW_ADDR_COND, 8'h00);
         setSupply(1'b1);
         wr(`LVIW_ADDR_OPT, 8'h30);
      end
   endtask
   // each timer flag gated by its own enable
   task tTimer;
      integer i;
      reg [7:0] b;
      begin
         for (i = 0; i < 3; i = i + 1) begin
            b = 8'h80 >> i;
            wr(`LVIW_ADDR_TCTL, ~b & 8'he0);
            @(posedge clk);
            timerEvent <= 3'b100 >> i;
            @(posedge clk);
            timerEvent <= 3'b000;
            seeIrq(1'b0);
            rd(`LVIW_ADDR_TSTAT, b);
            wr(`LVIW_ADDR_TCTL, b);
            seeIrq(1'b1);
            chk(vectorAddress, `LVIW_VEC_TIMER);
            rd(`LVIW_ADDR_VECTOR, 8'hf4);
            wr(`LVIW_ADDR_TSTAT, b);
            seeIrq(1'b0);
         end
         wr(`LVIW_ADDR_TCTL, 8'h00);
      end
   endtask
   task tKeypad;
      begin
         wr(`LVIW_ADDR_KEYCTL, 8'h02);
         @(posedge clk);
         keypadInputMask <= 8'h01;
         keypadPins_n <= 8'hfd;
         repeat (3) @(posedge clk);
         seeIrq(1'b0);
         @(posedge clk);
         keypadPins_n <= 8'hfe;
         repeat (3) @(posedge clk);
         seeIrq(1'b1);
         chk(vectorAddress, `LVIW_VEC_KEY);
         @(posedge clk);
         keypadPins_n <= 8'hff;
         wr(`LVIW_ADDR_KEYCTL, 8'h01);
         seeIrq(1'b0);
         rd(`LVIW_ADDR_KEYCTL, 8'h00);
      end
   endtask
   // stop woken by the pin rise, wait woken by external and core timer
   task tPower;
      integer i;
      begin
         setSupply(1'b0);
         wr(`LVIW_ADDR_OPT, 8'h30);
         wr(`LVIW_ADDR_KEYCTL, 8'h00);
         wr(`LVIW_ADDR_PWRCTL, 8'h01);
         chk({oscillatorEnable, timersRun, cpuRun}, 3'b000);
         setSupply(1'b1);
         seeIrq(1'b1);
         chk({oscillatorEnable, cpuRun}, 2'b11);
         wr(`LVIW_ADDR_OPT, 8'h30);
         for (i = 0; i < 2; i = i + 1) begin
            wr(`LVIW_ADDR_PWRCTL, 8'h02);
            chk({timersRun, cpuRun}, 2'b10);
            @(posedge clk);
            {externalIrqRequest, coreTimerRequest} <= 2'b10 >> i;
            repeat (2) @(posedge clk);
            @(negedge clk);
            chk(cpuRun, 1'b1);
            @(posedge clk);
            {externalIrqRequest, coreTimerRequest} <= 2'b00;
         end
      end
   endtask
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // hang guard
   initial begin
      repeat (20000) @(posedge clk);
      chk(1'b0, 1'b1);
      endOfTest;
   end
   initial begin
      nErrors = 0;
      testsRun = 0;
      {reset, powerOnReset, supplyOk, regWrite, regRead, vectorTaken} = 6'b110000;
      {regAddr, regWriteData, keypadInputMask} = {8'h00, 8'h00, 8'hff};
      {keypadPins_n, externalIrqRequest, coreTimerRequest, timerEvent} = {8'hff, 5'h00};
      repeat (20) @(posedge clk);
      reset <= 1'b0;
      tPowerOn;
      tEdges;
      tDisabled;
      tMask;
      tTimer;
      tKeypad;
      tPower;
      endOfTest;
   end
endmodule
